// [llpe_top.sv]
// Purpose: Link-layer performance event select, four counters, rate status
// Assumes: Event inputs come from logic on clk_i; rate/slow from PLL pins
// Notes: Counters read in two halves; low half read latches nothing
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Rate field bits 2:0 shows PLL rate setting, resets to 011
// - Bit 4 mirrors PLL slow-mode indication, resets to 0
// - Extra 0, code 00 counts group 0 transmit flits, two per cycle
// - Extra 0, code 01 counts group 0 receive flits, two per cycle
// - Codes 04-07 count transmit buffer inserts, bypasses, not-empty, fill
// - Codes 08-0B count receive inserts, bypasses, not-empty, fill up to 128
// - Codes 0C,0D,0F,10,12 count link power-state residency cycles
// - Code 14 counts one link clock tick each cycle
// - Extra 1, codes 00-03 count flits of groups 1 and 2
// - Extra 0, code 13 counts direct forwarding spawns
// - Extra 1, codes 09-0E class inserts; 15-1A class fill up to 128
// - Extra 1, codes 1B-1E shared credit returns and credit consumption
// - Extra 1, codes 1F-25 egress credit occupancy with class maxima
module llpe_top
  import llpe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [2:0] pll_rate_i,
  input wire logic pll_slow_i,
  input wire logic [1:0] tx_flit_count_grp0_i,
  input wire logic [1:0] rx_flit_count_grp0_i,
  input wire logic [1:0] tx_flit_grp1_i,
  input wire logic [1:0] tx_flit_grp2_i,
  input wire logic [1:0] rx_flit_grp1_i,
  input wire logic [1:0] rx_flit_grp2_i,
  input wire logic tx_buf_insert_i,
  input wire logic tx_buf_bypass_i,
  input wire logic tx_buf_not_empty_i,
  input wire logic tx_buffer_fill_i,
  input wire logic rx_buf_insert_i,
  input wire logic rx_buf_bypass_i,
  input wire logic rx_buf_not_empty_i,
  input wire logic [7:0] rx_queue_fill_i,
  input wire logic tx_full_width_i,
  input wire logic tx_half_lane_state_i,
  input wire logic rx_full_width_i,
  input wire logic rx_half_lane_state_i,
  input wire logic sleep_state_i,
  input wire logic fwd_spawn_i,
  input wire logic [NUM_CLS-1:0] rx_cls_insert_i,
  input wire logic [NUM_CLS*8-1:0] rx_cls_fill_i,
  input wire logic [7:0] shared_credit_pool_pend_i,
  input wire logic shared_credit_pool_ret_i,
  input wire logic shared_credit_pool_used_i,
  input wire logic [1:0] credit_channel_zero_used_i,
  input wire logic [NUM_EGR*8-1:0] egr_fill_i,
  output logic [2:0] rate_o,
  output logic slow_mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0] rate_s1;
    logic [2:0] rate;
    logic slow_s1;
    logic slow;
    logic [NUM_CTR-1:0][6:0] sel;
    logic [NUM_CTR-1:0][CTR_W-1:0] ctr;
    logic [31:0] rdata;
  } llpe_state_t;

  llpe_state_t s_q;
  llpe_state_t s_d;

  // Clamp an input count to its documented per-cycle ceiling
  function automatic logic [INC_W-1:0] llpe_clamp(input logic [INC_W-1:0] v,
                                                  input logic [INC_W-1:0] mx);
    llpe_clamp = (v > mx) ? mx : v;
  endfunction

  function automatic logic [INC_W-1:0] llpe_egr_max(input int unsigned k);
    logic [INC_W-1:0] m;
    m = MAX_EGR_AK;
    if (k == 0) m = MAX_EGR_DATA;
    else if (k < 3) m = MAX_EGR_BL;
    else if (k < 5) m = MAX_EGR_AD;
    else if (k == 5) m = MAX_EGR_ADNDR;
    llpe_egr_max = m;
  endfunction

  // Decode one select value into its per-cycle increment
  function automatic logic [INC_W-1:0] llpe_event(input logic [6:0] sel,
    input logic [NUM_CLS*8-1:0] cls_fill, input logic [NUM_EGR*8-1:0] egr,
    input logic [NUM_CLS-1:0] cls_ins);
    logic [INC_W-1:0] inc;
    logic [5:0] code;
    inc = 8'h00;
    code = sel[CODE_W-1:0];
    if (!sel[SEL_XBIT])
    begin
      unique case (code)
        // Two-bit flit inputs can show 3; hold them to the per-cycle ceiling
        EV_TX_FLIT_G0: inc = llpe_clamp({6'h00, tx_flit_count_grp0_i}, MAX_FLIT);
        EV_RX_FLIT_G0: inc = llpe_clamp({6'h00, rx_flit_count_grp0_i}, MAX_FLIT);
        EV_TX_INS: inc = {7'h00, tx_buf_insert_i};
        EV_TX_BYP: inc = {7'h00, tx_buf_bypass_i};
        EV_TX_NE: inc = {7'h00, tx_buf_not_empty_i};
        EV_TX_FILL: inc = {7'h00, tx_buffer_fill_i};
        EV_RX_INS: inc = {7'h00, rx_buf_insert_i};
        EV_RX_BYP: inc = {7'h00, rx_buf_bypass_i};
        EV_RX_NE: inc = {7'h00, rx_buf_not_empty_i};
        EV_RX_FILL: inc = llpe_clamp(rx_queue_fill_i, MAX_FILL);
        EV_TX_FULL: inc = {7'h00, tx_full_width_i};
        EV_TX_HALF: inc = {7'h00, tx_half_lane_state_i};
        EV_RX_FULL: inc = {7'h00, rx_full_width_i};
        EV_RX_HALF: inc = {7'h00, rx_half_lane_state_i};
        EV_SLEEP: inc = {7'h00, sleep_state_i};
        EV_FWD_SPAWN: inc = {7'h00, fwd_spawn_i};
        EV_CYCLES: inc = 8'h01;
        default: inc = 8'h00;
      endcase
    end
    else
    begin
      unique case (code)
        EV_TX_FLIT_G1: inc = llpe_clamp({6'h00, tx_flit_grp1_i}, MAX_FLIT);
        EV_TX_FLIT_G2: inc = llpe_clamp({6'h00, tx_flit_grp2_i}, MAX_FLIT);
        EV_RX_FLIT_G1: inc = llpe_clamp({6'h00, rx_flit_grp1_i}, MAX_FLIT);
        EV_RX_FLIT_G2: inc = llpe_clamp({6'h00, rx_flit_grp2_i}, MAX_FLIT);
        EV_SH_RET_PEND: inc = llpe_clamp(shared_credit_pool_pend_i, MAX_FILL);
        EV_SH_RET: inc = {7'h00, shared_credit_pool_ret_i};
        EV_SH_USED: inc = {7'h00, shared_credit_pool_used_i};
        EV_CH0_USED: inc = llpe_clamp({6'h00, credit_channel_zero_used_i}, MAX_FLIT);
        default: inc = 8'h00;
      endcase
      for (int k = 0; k < NUM_CLS; k++)
      begin
        if (code == EV_CLS_INS_BASE + 6'(k))
          inc = {7'h00, cls_ins[k]};
        if (code == EV_CLS_FILL_BASE + 6'(k))
          inc = llpe_clamp(cls_fill[k*8 +: 8], MAX_FILL);
      end
      for (int k = 0; k < NUM_EGR; k++)
      begin
        if (code == EV_EGR_BASE + 6'(k))
          inc = llpe_clamp(egr[k*8 +: 8], llpe_egr_max(k));
      end
    end
    llpe_event = inc;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    // Two-flop sync: PLL status comes from another domain
    s_d.rate_s1 = pll_rate_i;
    s_d.rate = s_q.rate_s1;
    s_d.slow_s1 = pll_slow_i;
    s_d.slow = s_q.slow_s1;
    s_d.rdata = 32'h0000_0000;

    for (int c = 0; c < NUM_CTR; c++)
    begin
      s_d.ctr[c] = s_q.ctr[c] + CTR_W'(llpe_event(s_q.sel[c], rx_cls_fill_i, egr_fill_i,
                                                  rx_cls_insert_i));
      if (wr_i && addr_i == OFF_CTR_SEL0 + 8'(c) * CTR_STRIDE)
      begin
        s_d.sel[c] = wdata_i[6:0];
        s_d.ctr[c] = '0; // Reselect restarts the count
      end
      if (rd_i && addr_i == OFF_CTR_SEL0 + 8'(c) * CTR_STRIDE)
        s_d.rdata = {25'h0000000, s_q.sel[c]};
      if (rd_i && addr_i == OFF_CTR_LO0 + 8'(c) * CTR_PAIR_STRIDE)
        s_d.rdata = s_q.ctr[c][31:0];
      if (rd_i && addr_i == OFF_CTR_HI0 + 8'(c) * CTR_PAIR_STRIDE)
        s_d.rdata = {16'h0000, s_q.ctr[c][CTR_W-1:32]};
    end

    // Status is read-only; writes to it are dropped
    if (rd_i && addr_i == OFF_RATE_STATUS)
    begin
      s_d.rdata = 32'h0000_0000;
      s_d.rdata[RATE_MSB:RATE_LSB] = s_q.rate;
      s_d.rdata[SLOW_BIT] = s_q.slow;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      s_q <= '0;
      s_q.rate_s1 <= RATE_RESET;
      s_q.rate <= RATE_RESET;
      s_q.slow <= 1'b0;
      for (int c = 0; c < NUM_CTR; c++)
        s_q.sel[c] <= SEL_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign rate_o = s_q.rate;
  assign slow_mode_o = s_q.slow;

endmodule
`default_nettype wire

// [llpe_pkg.sv]
// Purpose: Constants for the link-layer event select and rate status block
// Assumes: 50 MHz clock, plain register port
// Notes: Event codes are 5..6 bit codes plus one extra select bit
package llpe_pkg;
  localparam int unsigned NUM_CTR = 4;
  localparam int unsigned CTR_W = 48;
  localparam int unsigned INC_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CODE_W = 6;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_RATE_STATUS = 8'h00;
  localparam logic [7:0] OFF_CTR_SEL0 = 8'h04;
  localparam logic [7:0] OFF_CTR_LO0 = 8'h20;
  localparam logic [7:0] OFF_CTR_HI0 = 8'h24;
  localparam logic [7:0] CTR_STRIDE = 8'h04;
  localparam logic [7:0] CTR_PAIR_STRIDE = 8'h08;

  // Rate status layout
  localparam int unsigned RATE_LSB = 0;
  localparam int unsigned RATE_MSB = 2;
  localparam int unsigned SLOW_BIT = 4;
  localparam logic [2:0] RATE_RESET = 3'h3;
  localparam logic [2:0] RATE_6G4 = 3'h3;

  // Select register layout: [5:0] code, [6] extra select
  localparam int unsigned SEL_XBIT = 6;
  localparam logic [6:0] SEL_RESET = 7'h00;

  // Extra select 0 codes
  localparam logic [5:0] EV_TX_FLIT_G0 = 6'h00;
  localparam logic [5:0] EV_RX_FLIT_G0 = 6'h01;
  localparam logic [5:0] EV_TX_INS = 6'h04;
  localparam logic [5:0] EV_TX_BYP = 6'h05;
  localparam logic [5:0] EV_TX_NE = 6'h06;
  localparam logic [5:0] EV_TX_FILL = 6'h07;
  localparam logic [5:0] EV_RX_INS = 6'h08;
  localparam logic [5:0] EV_RX_BYP = 6'h09;
  localparam logic [5:0] EV_RX_NE = 6'h0A;
  localparam logic [5:0] EV_RX_FILL = 6'h0B;
  localparam logic [5:0] EV_TX_FULL = 6'h0C;
  localparam logic [5:0] EV_TX_HALF = 6'h0D;
  localparam logic [5:0] EV_RX_FULL = 6'h0F;
  localparam logic [5:0] EV_RX_HALF = 6'h10;
  localparam logic [5:0] EV_SLEEP = 6'h12;
  localparam logic [5:0] EV_FWD_SPAWN = 6'h13;
  localparam logic [5:0] EV_CYCLES = 6'h14;
  // Extra select 1 codes
  localparam logic [5:0] EV_TX_FLIT_G1 = 6'h00;
  localparam logic [5:0] EV_TX_FLIT_G2 = 6'h01;
  localparam logic [5:0] EV_RX_FLIT_G1 = 6'h02;
  localparam logic [5:0] EV_RX_FLIT_G2 = 6'h03;
  localparam logic [5:0] EV_CLS_INS_BASE = 6'h09;
  localparam logic [5:0] EV_CLS_FILL_BASE = 6'h15;
  localparam logic [5:0] EV_SH_RET_PEND = 6'h1B;
  localparam logic [5:0] EV_SH_RET = 6'h1C;
  localparam logic [5:0] EV_SH_USED = 6'h1D;
  localparam logic [5:0] EV_CH0_USED = 6'h1E;
  localparam logic [5:0] EV_EGR_BASE = 6'h1F;
  localparam int unsigned NUM_CLS = 6;
  localparam int unsigned NUM_EGR = 7;

  // Per-cycle maxima, used to clamp inputs
  localparam logic [7:0] MAX_FLIT = 8'h02;
  localparam logic [7:0] MAX_FILL = 8'h80;
  localparam logic [7:0] MAX_EGR_DATA = 8'h08;
  localparam logic [7:0] MAX_EGR_BL = 8'h02;
  localparam logic [7:0] MAX_EGR_AD = 8'h1C;
  localparam logic [7:0] MAX_EGR_ADNDR = 8'h08;
  localparam logic [7:0] MAX_EGR_AK = 8'h06;
endpackage

// [llpe_props.sv]
// Purpose: Port-level properties of the rate status and read port
// Assumes: Two-stage sync on PLL levels, one-cycle read data
// Notes: Counter decoding is left to the bench's table test
`timescale 1ns/10ps
`default_nettype none
module llpe_props
  import llpe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [2:0] pll_rate_i,
  input wire logic pll_slow_i,
  input wire logic [2:0] rate_o,
  input wire logic slow_mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  // Reset checks carry no disable, they look at the reset itself
  property p_rate_rst; !rstn_i |=> rate_o == RATE_RESET; endproperty
  a_rate_rst: assert property (p_rate_rst) else $error("rate not at reset value");
  property p_slow_rst; !rstn_i |=> !slow_mode_o; endproperty
  a_slow_rst: assert property (p_slow_rst) else $error("slow mode not cleared");
  property p_rate_sync;
    disable iff (!rstn_i) $past(rstn_i) && $past(rstn_i, 2) |-> rate_o == $past(pll_rate_i, 2);
  endproperty
  a_rate_sync: assert property (p_rate_sync) else $error("rate does not track pll");
  property p_slow_sync;
    disable iff (!rstn_i) rstn_i [*2] |=> slow_mode_o == $past(pll_slow_i, 2);
  endproperty
  a_slow_sync: assert property (p_slow_sync) else $error("slow mode does not track pll");
  sequence s_st_rd; rd_i && addr_i == OFF_RATE_STATUS; endsequence
  property p_rate_field;
    disable iff (!rstn_i) s_st_rd |=> rdata_o[2:0] == $past(rate_o);
  endproperty
  a_rate_field: assert property (p_rate_field) else $error("rate field wrong");
  property p_slow_field;
    disable iff (!rstn_i) s_st_rd |=> rdata_o[4] == $past(slow_mode_o);
  endproperty
  a_slow_field: assert property (p_slow_field) else $error("slow field wrong");
  property p_rsv_zero;
    disable iff (!rstn_i) s_st_rd |=> rdata_o[31:5] == 27'h0 && !rdata_o[3];
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");
  property p_idle_zero; disable iff (!rstn_i) !rd_i |=> rdata_o == 32'h0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside slot");
  c_status_rd: cover property (s_st_rd);
  c_slow_set: cover property (slow_mode_o && rate_o == RATE_6G4);
  c_rate_top: cover property (rate_o == 3'h7);
endmodule
bind llpe_top llpe_props llpe_props_i (.clk_i, .rstn_i, .addr_i, .rd_i, .rdata_o,
  .pll_rate_i, .pll_slow_i, .rate_o, .slow_mode_o);
`default_nettype wire

// [llpe_tb_top.sv]
// Purpose: Self-checking bench for event select and rate status
// Assumes: One-cycle read data, no wait states
// Notes: All events driven at once; only the class fills take distinct values
`timescale 1ns/10ps
`default_nettype none
module llpe_tb_top
  import llpe_pkg::*;
;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0, rd_i = 1'b0, pll_slow_i = 1'b0, slow_mode_o;
  logic [31:0] rdata_o, v, w;
  logic [2:0] pll_rate_i = 3'h5, rate_o;
  logic [1:0] tx_flit_count_grp0_i, rx_flit_count_grp0_i, tx_flit_grp1_i, tx_flit_grp2_i;
  logic [1:0] rx_flit_grp1_i, rx_flit_grp2_i, credit_channel_zero_used_i;
  logic tx_buf_insert_i, tx_buf_bypass_i, tx_buf_not_empty_i, tx_buffer_fill_i;
  logic rx_buf_insert_i, rx_buf_bypass_i, rx_buf_not_empty_i, tx_full_width_i;
  logic tx_half_lane_state_i, rx_full_width_i, rx_half_lane_state_i, sleep_state_i;
  logic fwd_spawn_i, shared_credit_pool_ret_i, shared_credit_pool_used_i;
  logic [NUM_CLS-1:0] rx_cls_insert_i;
  logic [NUM_CLS*8-1:0] rx_cls_fill_i;
  logic [7:0] rx_queue_fill_i, shared_credit_pool_pend_i;
  logic [NUM_EGR*8-1:0] egr_fill_i;
  logic [15:0] e;
  int c;
  int n_errors = 0;
  int cmp_count = 0;
  // Entry: extra bit 14, code 13:8, expected per-cycle increment 7:0
  localparam logic [15:0] EV_TAB [43] = '{16'h0002, 16'h0102, 16'h0401, 16'h0501, 16'h0601,
    16'h0701, 16'h0801, 16'h0901, 16'h0A01, 16'h0B80, 16'h0C01, 16'h0D01, 16'h0F01, 16'h1001,
    16'h1201, 16'h1301, 16'h4002, 16'h4102, 16'h4202, 16'h4302, 16'h4901, 16'h4A01, 16'h4B01,
    16'h4C01, 16'h4D01, 16'h4E01, 16'h5520, 16'h5640, 16'h5760, 16'h5880, 16'h5980, 16'h5A80,
    16'h5B80, 16'h5C01, 16'h5D01, 16'h5E02, 16'h5F08, 16'h6002, 16'h6102, 16'h621C, 16'h631C,
    16'h6408, 16'h6506};
  llpe_top llpe_top_i (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pll_rate_i,
    .pll_slow_i, .tx_flit_count_grp0_i, .rx_flit_count_grp0_i, .tx_flit_grp1_i, .tx_flit_grp2_i,
    .rx_flit_grp1_i, .rx_flit_grp2_i, .tx_buf_insert_i, .tx_buf_bypass_i, .tx_buf_not_empty_i,
    .tx_buffer_fill_i, .rx_buf_insert_i, .rx_buf_bypass_i, .rx_buf_not_empty_i, .rx_queue_fill_i,
    .tx_full_width_i, .tx_half_lane_state_i, .rx_full_width_i, .rx_half_lane_state_i,
    .sleep_state_i, .fwd_spawn_i, .rx_cls_insert_i, .rx_cls_fill_i, .shared_credit_pool_pend_i,
    .shared_credit_pool_ret_i, .shared_credit_pool_used_i, .credit_channel_zero_used_i,
    .egr_fill_i, .rate_o, .slow_mode_o);
  initial forever #10 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  // Inputs above the maxima on purpose, so clamping shows in the counts
  task automatic set_ev(input logic on);
    {tx_flit_count_grp0_i, rx_flit_count_grp0_i, tx_flit_grp1_i, tx_flit_grp2_i, rx_flit_grp1_i,
      rx_flit_grp2_i, credit_channel_zero_used_i} <= on ? 14'h3FFF : 14'h0000;
    {tx_buf_insert_i, tx_buf_bypass_i, tx_buf_not_empty_i, tx_buffer_fill_i, rx_buf_insert_i,
      rx_buf_bypass_i, rx_buf_not_empty_i, tx_full_width_i, tx_half_lane_state_i,
      rx_full_width_i, rx_half_lane_state_i, sleep_state_i, fwd_spawn_i,
      shared_credit_pool_ret_i, shared_credit_pool_used_i} <= {15{on}};
    rx_cls_insert_i <= {NUM_CLS{on}};
    rx_cls_fill_i <= on ? 48'hC0A080604020 : 48'h0;
    rx_queue_fill_i <= on ? 8'hC8 : 8'h00;
    shared_credit_pool_pend_i <= on ? 8'hFF : 8'h00;
    egr_fill_i <= on ? {NUM_EGR{8'hFF}} : '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    set_ev(1'b0);
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(OFF_RATE_STATUS, v);
    check("status reset", v, 32'h3);
    for (int r = 2; r < 8; r++)
    begin
      pll_rate_i <= 3'(r);
      pll_slow_i <= (r == 3);
      repeat (4) @(posedge clk_i);
      rd(OFF_RATE_STATUS, v);
      check("status", v, {27'h0, r == 3, 1'b0, 3'(r)});
      check("rate pin", {28'h0, slow_mode_o, rate_o}, {28'h0, r == 3, 3'(r)});
    end
    wr(OFF_RATE_STATUS, 32'h0);
    rd(OFF_RATE_STATUS, v);
    check("status after write", v, 32'h7);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(OFF_RATE_STATUS, v);
    check("status second reset", v, 32'h3);
    $display("test status done");
    for (int i = 0; i < 43; i++)
    begin
      e = EV_TAB[i];
      c = i % 4;
      wr(OFF_CTR_SEL0 + 8'(4 * c), {25'h0, e[14:8]});
      @(posedge clk_i);
      set_ev(1'b1);
      repeat (3) @(posedge clk_i);
      set_ev(1'b0);
      rd(OFF_CTR_LO0 + 8'(8 * c), v);
      if (e[14]) check("ctr x1", v, 32'(3 * e[7:0]));
      else check("ctr x0", v, 32'(3 * e[7:0]));
    end
    rd(OFF_CTR_HI0, v);
    check("ctr high", v, 32'h0);
    rd(8'hFC, v);
    check("unmapped", v, 32'h0);
    $display("test events done");
    wr(OFF_CTR_SEL0, {25'h0, 1'b0, EV_CYCLES});
    rd(OFF_CTR_LO0, v);
    rd(OFF_CTR_LO0, w);
    check("ticks", w - v, 32'h2);
    $display("test ticks done");
    tally_and_finish();
  end
  // Guard against a hang
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
